// File: rtl/pf_pkg.sv
// Constants and types of the low power factor protection stage
//------------------------------------------------------------
// Overview of operation
// - Protected quantity is power factor P over S.
// - Static operating mode, default On, reported back.
// - Forcing overrides the reported status, default Normal.
// - Static selection of measurement module, default first.
// - Pick up below trip or alarm level.
// - Release above 103 percent of pick-up level.
// - Group settings change while the stage runs.
// - Trips-only mode disables the alarm path.
// - Trip level in 0.01 steps, default 0.8.
// - Alarm level default 0.9, trips-and-alarms only.
// - Report expected and remaining trip time, 5 ms.
// - Report expected and remaining alarm time, 5 ms.
// - Report measured to trip level ratio, 0.01.
// - Report measured to alarm level ratio, 0.01.
// - Report one of six conditions.
// - Sample blocking input at each program cycle start.
// - Unblocked pick-up asserts start, starts timing.
// - Blocked pick-up asserts blocked, no trip timing.
// - Late blocking clears start, resets trip timing to zero.
// - Definite time delays only.
// - On/off events and resettable occurrence counters.
// - Twelve-deep ring of start/trip/blocked records.
//------------------------------------------------------------
package pf_pkg;
  localparam int PF_W = 8;
  localparam int LVL_W = 7;
  localparam int TIME_W = 19;
  localparam int RATIO_W = 14;
  localparam int CNT_W = 16;
  localparam int GROUP_W = 3;
  localparam int PCT = 100;
  localparam int HYST_PCT = 103;
  localparam int LVL_MIN = 5;
  localparam int LVL_MAX = 99;
  localparam logic [LVL_W-1:0] TRIP_LEVEL_RST = 7'h50;
  localparam logic [LVL_W-1:0] ALARM_LEVEL_RST = 7'h5A;
  localparam logic [TIME_W-1:0] TRIP_DELAY_RST = 19'h000C8;
  localparam logic [TIME_W-1:0] ALARM_DELAY_RST = 19'h000C8;
  localparam int CALC_PERIOD_MS = 5;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int PRE_TRIG_SAMPLES = PRE_TRIG_MS / CALC_PERIOD_MS;
  localparam int PRE_FAULT_SAMPLES = PRE_FAULT_MS / CALC_PERIOD_MS;
  localparam int RING_DEPTH = 12;
  localparam int RING_W = 4;
  localparam int NUM_EV = 5;
  localparam int EV_BLOCK = 0;
  localparam int EV_START = 1;
  localparam int EV_TRIP = 2;
  localparam int EV_ALARM_START = 3;
  localparam int EV_ALARM = 4;
  typedef enum logic [2:0] {
    MODE_ON = 3'b000, MODE_BLOCKED = 3'b001, MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011, MODE_OFF = 3'b100
  } logical_node_operating_mode_t;
  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000, COND_START = 3'b001, COND_TRIP = 3'b010,
    COND_BLOCKED = 3'b011, COND_ALARM_START = 3'b100, COND_ALARM = 3'b101
  } cond_t;
endpackage

// File: rtl/pf_stage_if.sv
// Interfaces between the stage and its timer and divider units
`timescale 1ns/1ps
interface dt_timer_if;
  logic run;
  logic step;
  logic [pf_pkg::TIME_W-1:0] delay;
  logic [pf_pkg::TIME_W-1:0] remaining;
  logic expired;
  modport owner (output run, output step, output delay, input remaining, input expired);
  modport timer (input run, input step, input delay, output remaining, output expired);
endinterface // dt_timer_if

interface ratio_div_if;
  logic go;
  logic [pf_pkg::RATIO_W-1:0] num;
  logic [pf_pkg::LVL_W-1:0] den;
  logic done;
  logic [pf_pkg::RATIO_W-1:0] quo;
  modport owner (output go, output num, output den, input done, input quo);
  modport unit (input go, input num, input den, output done, output quo);
endinterface // ratio_div_if

// File: rtl/pf_dt_timer.sv
// Definite time delay counter stepped once per program cycle
`timescale 1ns/1ps
module pf_dt_timer
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Owner side
  dt_timer_if.timer t
);
  logic [pf_pkg::TIME_W-1:0] count;

  // Count steps while running, restart from zero when released
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      count <= '0;
    else if (ce)
    begin
      if (!t.run)
        count <= '0;
      else if (t.step && count < t.delay)
        count <= count + 1'b1;
    end
  end

  // Fixed delay only, no inverse characteristic
  assign t.expired = t.run && (count >= t.delay);
  assign t.remaining = (count >= t.delay) ? '0 : t.delay - count;
endmodule // pf_dt_timer

// File: rtl/pf_ratio_div.sv
// Serial restoring divider for measured-to-level ratios
`timescale 1ns/1ps
module pf_ratio_div
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Owner side
  ratio_div_if.unit d
);
  localparam int NW = pf_pkg::RATIO_W;
  localparam int DW = pf_pkg::LVL_W;
  logic [DW:0] rem;
  logic [NW-1:0] quo;
  logic [4:0] left;
  logic busy;
  logic [DW:0] next_rem;
  logic next_bit;

  // One quotient bit per cycle
  always_comb
  begin
    next_rem = {rem[DW-1:0], quo[NW-1]};
    next_bit = 1'b0;
    if (next_rem >= {1'b0, d.den})
    begin
      next_rem = next_rem - {1'b0, d.den};
      next_bit = 1'b1;
    end
  end

  // Sequencing of a division
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rem <= '0;
      quo <= '0;
      left <= '0;
      busy <= 1'b0;
      d.done <= 1'b0;
    end
    else if (ce)
    begin
      d.done <= 1'b0;
      if (d.go && !busy)
      begin
        rem <= '0;
        quo <= d.num;
        left <= 5'(NW);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem <= next_rem;
        quo <= {quo[NW-2:0], next_bit};
        left <= left - 1'b1;
        if (left == 5'h01)
        begin
          busy <= 1'b0;
          d.done <= 1'b1;
        end
      end
    end
  end

  assign d.quo = quo;
endmodule // pf_ratio_div

// File: rtl/pf_protection_stage.sv
// Low power factor protection stage with timing, events and records
`timescale 1ns/1ps
module pf_protection_stage
#(
  parameter int RING = pf_pkg::RING_DEPTH
)
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Measurement modules, new value per program cycle
  input wire logic signed [pf_pkg::PF_W-1:0] pf_one,
  input wire logic signed [pf_pkg::PF_W-1:0] pf_two,
  input wire logic pf_valid,
  // Blocking matrix input
  input wire logic blk_in,
  // Settings, taken on set_load
  input wire logic set_load,
  input wire pf_pkg::logical_node_operating_mode_t set_mode,
  input wire logic set_meas_sel,
  input wire logic set_force_en,
  input wire pf_pkg::cond_t set_force_cond,
  input wire logic set_alarms_en,
  input wire logic [pf_pkg::LVL_W-1:0] set_trip_level,
  input wire logic [pf_pkg::LVL_W-1:0] set_alarm_level,
  input wire logic [pf_pkg::TIME_W-1:0] set_trip_delay,
  input wire logic [pf_pkg::TIME_W-1:0] set_alarm_delay,
  input wire logic [pf_pkg::GROUP_W-1:0] set_group,
  // Counter clear and record selection
  input wire logic cnt_clear,
  input wire logic [pf_pkg::RING_W-1:0] rec_sel,
  // Protection outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic alarm_start_out,
  output logic alarm_out,
  // Supervision values
  output pf_pkg::cond_t condition,
  output pf_pkg::logical_node_operating_mode_t mode_now,
  output logic [pf_pkg::TIME_W-1:0] trip_expected,
  output logic [pf_pkg::TIME_W-1:0] trip_remaining,
  output logic [pf_pkg::TIME_W-1:0] alarm_expected,
  output logic [pf_pkg::TIME_W-1:0] alarm_remaining,
  output logic [pf_pkg::RATIO_W-1:0] trip_level_ratio,
  output logic [pf_pkg::RATIO_W-1:0] alarm_level_ratio,
  // Events and counters
  output logic [pf_pkg::NUM_EV-1:0] event_on,
  output logic [pf_pkg::NUM_EV-1:0] event_off,
  output logic [pf_pkg::NUM_EV-1:0][pf_pkg::CNT_W-1:0] event_count,
  // Selected record
  output logic rec_valid,
  output pf_pkg::cond_t rec_event,
  output logic [pf_pkg::LVL_W-1:0] rec_pre_trig,
  output logic [pf_pkg::LVL_W-1:0] rec_fault,
  output logic [pf_pkg::LVL_W-1:0] rec_pre_fault,
  output logic [pf_pkg::TIME_W-1:0] rec_remaining,
  output logic [pf_pkg::GROUP_W-1:0] rec_group
);
  localparam int LW = pf_pkg::LVL_W;
  localparam int HD = pf_pkg::PRE_FAULT_SAMPLES;

  // Ring depth must stay below the range of the record index
  if (RING < 1 || RING >= (1 << pf_pkg::RING_W))
  begin : g_bad_ring
    $error("RING out of range");
  end

  //----------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------
  // Magnitude of signed power factor, capped at 1.00
  function automatic logic [LW-1:0] pf_mag(input logic signed [pf_pkg::PF_W-1:0] v);
    logic [pf_pkg::PF_W-1:0] a;
    a = v[pf_pkg::PF_W-1] ? pf_pkg::PF_W'(-v) : pf_pkg::PF_W'(v);
    return (a > pf_pkg::PF_W'(pf_pkg::PCT)) ? LW'(pf_pkg::PCT) : a[LW-1:0];
  endfunction

  // Keep a level inside the settable range
  function automatic logic [LW-1:0] clamp_level(input logic [LW-1:0] l);
    if (l < LW'(pf_pkg::LVL_MIN))
      return LW'(pf_pkg::LVL_MIN);
    else if (l > LW'(pf_pkg::LVL_MAX))
      return LW'(pf_pkg::LVL_MAX);
    return l;
  endfunction

  // Pick-up state with fixed release hysteresis
  function automatic logic pickup(input logic held, input logic [LW-1:0] m,
                                  input logic [LW-1:0] l);
    if (!held)
      return m < l;
    return !((14'(m) * 14'(pf_pkg::PCT)) > (14'(l) * 14'(pf_pkg::HYST_PCT)));
  endfunction

  //----------------------------------------------------------
  // Settings
  //----------------------------------------------------------
  pf_pkg::logical_node_operating_mode_t mode;
  logic meas_sel;
  logic force_en;
  pf_pkg::cond_t force_cond;
  logic alarms_en;
  logic [LW-1:0] trip_level;
  logic [LW-1:0] alarm_level;
  logic [pf_pkg::TIME_W-1:0] trip_delay;
  logic [pf_pkg::TIME_W-1:0] alarm_delay;
  logic [pf_pkg::GROUP_W-1:0] group;

  // Static and group settings, defaults after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mode <= pf_pkg::MODE_ON;
      meas_sel <= 1'b0;
      force_en <= 1'b0;
      force_cond <= pf_pkg::COND_NORMAL;
      alarms_en <= 1'b1;
      trip_level <= pf_pkg::TRIP_LEVEL_RST;
      alarm_level <= pf_pkg::ALARM_LEVEL_RST;
      trip_delay <= pf_pkg::TRIP_DELAY_RST;
      alarm_delay <= pf_pkg::ALARM_DELAY_RST;
      group <= '0;
    end
    else if (ce && set_load)
    begin
      mode <= set_mode;
      meas_sel <= set_meas_sel;
      force_en <= set_force_en;
      force_cond <= set_force_cond;
      alarms_en <= set_alarms_en;
      trip_level <= clamp_level(set_trip_level);
      alarm_level <= clamp_level(set_alarm_level);
      trip_delay <= set_trip_delay;
      alarm_delay <= set_alarm_delay;
      group <= set_group;
    end
  end

  //----------------------------------------------------------
  // Sampling of the program cycle
  //----------------------------------------------------------
  logic [LW-1:0] mag;
  logic blk;
  logic eval;
  logic [LW-1:0] hist [HD];

  // Capture magnitude and block at the cycle start
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mag <= '0;
      blk <= 1'b0;
      eval <= 1'b0;
    end
    else if (ce)
    begin
      eval <= pf_valid;
      if (pf_valid)
      begin
        mag <= pf_mag(meas_sel ? pf_two : pf_one);
        blk <= blk_in;
      end
    end
  end

  // Power factor history for pre-trigger and pre-fault values
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < HD; i++)
        hist[i] <= '0;
    end
    else if (ce && pf_valid)
    begin
      hist[0] <= mag;
      for (int i = 1; i < HD; i++)
        hist[i] <= hist[i-1];
    end
  end

  //----------------------------------------------------------
  // Pick-up, start, block and timing
  //----------------------------------------------------------
  dt_timer_if trip_t ();
  dt_timer_if alarm_t ();
  logic trip_pu;
  logic alarm_pu;
  logic st;
  logic tr;
  logic bl;
  logic ast;
  logic al;
  logic active;
  logic blk_eff;
  logic next_trip_pu;
  logic next_alarm_pu;

  assign active = (mode != pf_pkg::MODE_OFF);
  assign blk_eff = blk || mode == pf_pkg::MODE_BLOCKED || mode == pf_pkg::MODE_TEST_BLOCKED;
  assign next_trip_pu = active && pickup(trip_pu, mag, trip_level);
  assign next_alarm_pu = active && alarms_en && pickup(alarm_pu, mag, alarm_level);

  // Stage state, updated once per program cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      trip_pu <= 1'b0;
      alarm_pu <= 1'b0;
      st <= 1'b0;
      tr <= 1'b0;
      bl <= 1'b0;
      ast <= 1'b0;
      al <= 1'b0;
    end
    else if (ce && eval)
    begin
      trip_pu <= next_trip_pu;
      alarm_pu <= next_alarm_pu;
      st <= next_trip_pu && !blk_eff;
      bl <= (next_trip_pu || next_alarm_pu) && blk_eff;
      tr <= next_trip_pu && !blk_eff && (tr || trip_t.expired);
      ast <= next_alarm_pu && !blk_eff;
      al <= next_alarm_pu && !blk_eff && (al || alarm_t.expired);
    end
  end

  // Definite time counters run only while started
  assign trip_t.run = st;
  assign trip_t.step = eval;
  assign trip_t.delay = trip_delay;
  assign alarm_t.run = ast;
  assign alarm_t.step = eval;
  assign alarm_t.delay = alarm_delay;

  pf_dt_timer u_trip_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .t(trip_t));
  pf_dt_timer u_alarm_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .t(alarm_t));

  //----------------------------------------------------------
  // Ratios of measurement to levels
  //----------------------------------------------------------
  ratio_div_if trip_d ();
  ratio_div_if alarm_d ();

  assign trip_d.go = eval;
  assign trip_d.num = pf_pkg::RATIO_W'(14'(mag) * 14'(pf_pkg::PCT));
  assign trip_d.den = trip_level;
  assign alarm_d.go = eval;
  assign alarm_d.num = trip_d.num;
  assign alarm_d.den = alarm_level;

  pf_ratio_div u_trip_div (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(trip_d));
  pf_ratio_div u_alarm_div (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(alarm_d));

  //----------------------------------------------------------
  // Reported status and outputs
  //----------------------------------------------------------
  pf_pkg::cond_t next_cond;
  logic [pf_pkg::NUM_EV-1:0] flags;
  logic [pf_pkg::NUM_EV-1:0] next_flags;
  logic out_en;

  // Condition by priority, forcing overrides
  always_comb
  begin
    if (force_en)
      next_cond = force_cond;
    else if (bl)
      next_cond = pf_pkg::COND_BLOCKED;
    else if (tr)
      next_cond = pf_pkg::COND_TRIP;
    else if (st)
      next_cond = pf_pkg::COND_START;
    else if (al)
      next_cond = pf_pkg::COND_ALARM;
    else if (ast)
      next_cond = pf_pkg::COND_ALARM_START;
    else
      next_cond = pf_pkg::COND_NORMAL;
  end

  assign out_en = (mode == pf_pkg::MODE_ON || mode == pf_pkg::MODE_BLOCKED);
  assign next_flags[pf_pkg::EV_BLOCK] = force_en ? next_cond == pf_pkg::COND_BLOCKED : bl;
  assign next_flags[pf_pkg::EV_START] = force_en ? next_cond == pf_pkg::COND_START : st;
  assign next_flags[pf_pkg::EV_TRIP] = force_en ? next_cond == pf_pkg::COND_TRIP : tr;
  assign next_flags[pf_pkg::EV_ALARM_START] =
    force_en ? next_cond == pf_pkg::COND_ALARM_START : ast;
  assign next_flags[pf_pkg::EV_ALARM] = force_en ? next_cond == pf_pkg::COND_ALARM : al;

  // Registered supervision outputs
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      condition <= pf_pkg::COND_NORMAL;
      mode_now <= pf_pkg::MODE_ON;
      flags <= '0;
      {start_out, trip_out, blocked_out, alarm_start_out, alarm_out} <= '0;
      trip_expected <= '0;
      trip_remaining <= '0;
      alarm_expected <= '0;
      alarm_remaining <= '0;
      trip_level_ratio <= '0;
      alarm_level_ratio <= '0;
    end
    else if (ce)
    begin
      condition <= next_cond;
      mode_now <= mode;
      flags <= next_flags;
      start_out <= out_en && next_flags[pf_pkg::EV_START];
      trip_out <= out_en && next_flags[pf_pkg::EV_TRIP];
      blocked_out <= out_en && next_flags[pf_pkg::EV_BLOCK];
      alarm_start_out <= out_en && next_flags[pf_pkg::EV_ALARM_START];
      alarm_out <= out_en && next_flags[pf_pkg::EV_ALARM];
      trip_expected <= st ? trip_delay : '0;
      trip_remaining <= st ? trip_t.remaining : '0;
      alarm_expected <= ast ? alarm_delay : '0;
      alarm_remaining <= ast ? alarm_t.remaining : '0;
      if (trip_d.done)
        trip_level_ratio <= trip_d.quo;
      if (alarm_d.done)
        alarm_level_ratio <= alarms_en ? alarm_d.quo : '0;
    end
  end

  //----------------------------------------------------------
  // Events and counters
  //----------------------------------------------------------
  logic [pf_pkg::NUM_EV-1:0] rise;

  assign rise = next_flags & ~flags;

  // Edge events and occurrence counts, a new event wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      event_on <= '0;
      event_off <= '0;
      event_count <= '0;
    end
    else if (ce)
    begin
      event_on <= rise;
      event_off <= flags & ~next_flags;
      for (int i = 0; i < pf_pkg::NUM_EV; i++)
      begin
        if (rise[i])
          event_count[i] <= cnt_clear ? pf_pkg::CNT_W'(1) : event_count[i] + 1'b1;
        else if (cnt_clear)
          event_count[i] <= '0;
      end
    end
  end

  //----------------------------------------------------------
  // Record ring
  //----------------------------------------------------------
  pf_pkg::cond_t ring_ev [RING];
  logic [3*LW-1:0] ring_pf [RING];
  logic [pf_pkg::TIME_W-1:0] ring_rem [RING];
  logic [pf_pkg::GROUP_W-1:0] ring_grp [RING];
  logic [RING-1:0] ring_used;
  logic [pf_pkg::RING_W-1:0] wr_ptr;
  logic rec_hit;
  pf_pkg::cond_t rec_code;

  assign rec_hit = rise[pf_pkg::EV_START] || rise[pf_pkg::EV_TRIP] || rise[pf_pkg::EV_BLOCK];
  assign rec_code = rise[pf_pkg::EV_TRIP] ? pf_pkg::COND_TRIP :
                    rise[pf_pkg::EV_START] ? pf_pkg::COND_START : pf_pkg::COND_BLOCKED;

  // Oldest record is overwritten
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      ring_used <= '0;
    end
    else if (ce && rec_hit)
    begin
      ring_ev[wr_ptr] <= rec_code;
      ring_pf[wr_ptr] <= {hist[pf_pkg::PRE_TRIG_SAMPLES-1], mag, hist[HD-1]};
      ring_rem[wr_ptr] <= trip_t.remaining;
      ring_grp[wr_ptr] <= group;
      ring_used[wr_ptr] <= 1'b1;
      wr_ptr <= (wr_ptr == pf_pkg::RING_W'(RING - 1)) ? '0 : wr_ptr + 1'b1;
    end
  end

  // Registered readback of the selected record
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rec_valid <= 1'b0;
      rec_event <= pf_pkg::COND_NORMAL;
      {rec_pre_trig, rec_fault, rec_pre_fault} <= '0;
      rec_remaining <= '0;
      rec_group <= '0;
    end
    else if (ce)
    begin
      rec_valid <= (rec_sel < pf_pkg::RING_W'(RING)) && ring_used[rec_sel];
      if ((rec_sel < pf_pkg::RING_W'(RING)) && ring_used[rec_sel])
      begin
        rec_event <= ring_ev[rec_sel];
        {rec_pre_trig, rec_fault, rec_pre_fault} <= ring_pf[rec_sel];
        rec_remaining <= ring_rem[rec_sel];
        rec_group <= ring_grp[rec_sel];
      end
    end
  end
endmodule // pf_protection_stage

// File: verification/pf_meas_model.sv
// Model of the power measurement source feeding the stage
`timescale 1ns/1ps
module pf_meas_model
#(
  parameter int PERIOD = 20
)
(
  // Clock
  input wire logic clk_sys,
  // Value to deliver from the first module
  input wire logic signed [pf_pkg::PF_W-1:0] pf_val,
  // Samples towards the stage
  output logic signed [pf_pkg::PF_W-1:0] pf_one = 8'sh00,
  output logic signed [pf_pkg::PF_W-1:0] pf_two,
  output logic pf_valid = 1'b0
);
  int cnt = 0;
  // One fresh sample per shortened program cycle
  always @(negedge clk_sys)
  begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    pf_valid <= (cnt == 0);
    pf_one <= pf_val;
  end
  // Second module reports a healthy load
  assign pf_two = 8'sh5F;
endmodule // pf_meas_model

// File: verification/pf_stage_assertions.sv
// Concurrent checks on the ports of the protection stage
`timescale 1ns/1ps
module pf_stage_assertions
#(
  parameter int RING = pf_pkg::RING_DEPTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Watched signals
  input wire logic set_load,
  input wire pf_pkg::logical_node_operating_mode_t set_mode,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire pf_pkg::cond_t condition,
  input wire pf_pkg::logical_node_operating_mode_t mode_now,
  input wire logic [pf_pkg::TIME_W-1:0] trip_expected,
  input wire logic [pf_pkg::TIME_W-1:0] trip_remaining,
  input wire logic [pf_pkg::NUM_EV-1:0] event_on,
  input wire logic [pf_pkg::NUM_EV-1:0][pf_pkg::CNT_W-1:0] event_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  chk_mode_follow: assert property (set_load |-> ##2 mode_now == $past(set_mode, 2))
    else $error("mode in effect does not follow load");
  chk_block_excl: assert property (!(blocked_out && start_out))
    else $error("blocked and start together");
  chk_start_event: assert property ($rose(start_out) && $stable(mode_now) |-> event_on[1])
    else $error("start rose without event");
  chk_remain_bound: assert property (trip_remaining <= trip_expected)
    else $error("remaining above expected");
  chk_trip_after: assert property ($rose(trip_out) |->
    $past(condition) == pf_pkg::COND_START)
    else $error("trip without preceding start");
  chk_count_step: assert property ($changed(event_count[1]) |->
    event_count[1] == $past(event_count[1]) + 16'h0001 || event_count[1] <= 16'h0001)
    else $error("start counter jumped");
  chk_event_pulse: assert property (event_on[1] |=> !event_on[1])
    else $error("start event longer than one cycle");
  chk_test_quiet: assert property (mode_now == pf_pkg::MODE_TEST &&
    $past(mode_now) == pf_pkg::MODE_TEST |-> !start_out && !trip_out)
    else $error("pins active in test mode");
  // Main scenarios
  cov_trip: cover property ($rose(trip_out));
  cov_block: cover property ($rose(blocked_out));
  cov_test: cover property (mode_now == pf_pkg::MODE_TEST);
endmodule // pf_stage_assertions
bind pf_protection_stage pf_stage_assertions #(.RING(RING)) pf_stage_assertions_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .set_load(set_load), .set_mode(set_mode),
  .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
  .condition(condition), .mode_now(mode_now), .trip_expected(trip_expected),
  .trip_remaining(trip_remaining), .event_on(event_on), .event_count(event_count));

// File: verification/power_factor_protection_stage_tb.sv
// Self-checking testbench of the protection stage
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module power_factor_protection_stage_tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, set_load = 1'b0, set_meas_sel = 1'b0;
  logic set_alarms_en = 1'b1, blk_in = 1'b0, cnt_clear = 1'b0, pf_valid;
  pf_pkg::logical_node_operating_mode_t set_mode = pf_pkg::MODE_ON;
  logic [6:0] set_trip_level = 7'h50, set_alarm_level = 7'h5A;
  logic [18:0] set_delay = 19'h00003;
  logic signed [7:0] pf_val = 8'sh5F, pf_one, pf_two;
  logic start_out, trip_out, blocked_out, alarm_start_out, alarm_out;
  pf_pkg::cond_t condition;
  pf_pkg::logical_node_operating_mode_t mode_now;
  logic [18:0] trip_expected, alarm_expected;
  logic [13:0] trip_level_ratio, alarm_level_ratio;
  logic [4:0][15:0] event_count;
  logic [6:0] rec_fault;
  int failures = 0, n_tests = 0;
  // Free running clock
  always #10 clk_sys = ~clk_sys;
  pf_meas_model pf_meas_model_i (.clk_sys(clk_sys), .pf_val(pf_val), .pf_one(pf_one),
    .pf_two(pf_two), .pf_valid(pf_valid));
  pf_protection_stage pf_protection_stage_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
    .pf_one(pf_one), .pf_two(pf_two), .pf_valid(pf_valid), .blk_in(blk_in),
    .set_load(set_load), .set_mode(set_mode), .set_meas_sel(set_meas_sel),
    .set_force_en(1'b0), .set_force_cond(pf_pkg::COND_NORMAL), .set_alarms_en(set_alarms_en),
    .set_trip_level(set_trip_level), .set_alarm_level(set_alarm_level),
    .set_trip_delay(set_delay), .set_alarm_delay(set_delay), .set_group(3'h1),
    .cnt_clear(cnt_clear), .rec_sel(4'h0), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .alarm_start_out(alarm_start_out), .alarm_out(alarm_out),
    .condition(condition), .mode_now(mode_now), .trip_expected(trip_expected),
    .trip_remaining(), .alarm_expected(alarm_expected), .alarm_remaining(),
    .trip_level_ratio(trip_level_ratio), .alarm_level_ratio(alarm_level_ratio),
    .event_on(), .event_off(), .event_count(event_count), .rec_valid(), .rec_event(),
    .rec_pre_trig(), .rec_fault(rec_fault), .rec_pre_fault(), .rec_remaining(), .rec_group());
  //------------------------------------------------------------
  // Helper tasks
  //------------------------------------------------------------
  // Wait n samples, then until outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge pf_valid);
    repeat (3) @(negedge clk_sys);
  endtask
  // Load settings with a one-cycle strobe
  task automatic ld(input pf_pkg::logical_node_operating_mode_t m, input logic al, input logic [6:0] tl, al_l);
    @(negedge clk_sys);
    set_mode = m;
    set_alarms_en = al;
    set_trip_level = tl;
    set_alarm_level = al_l;
    set_load = 1'b1;
    @(negedge clk_sys);
    set_load = 1'b0;
  endtask
  // Return to a healthy load
  task automatic heal();
    blk_in = 1'b0;
    pf_val = 8'sh5F;
    step(1);
  endtask
  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_trip();
    ld(pf_pkg::MODE_ON, 1'b1, 7'h50, 7'h32);
    pf_val = -8'sh46;
    step(1);
    `CHK(start_out, 1'b1)
    `CHK(trip_expected, 19'h00003)
    `CHK(event_count[1], 16'h0001)
    step(3);
    `CHK(trip_out, 1'b0)
    `CHK(rec_fault, 7'h46)
    step(1);
    `CHK(condition, pf_pkg::COND_TRIP)
    pf_val = 8'sh52;
    step(1);
    `CHK(start_out | trip_out, 1'b1)
    pf_val = 8'sh53;
    step(1);
    `CHK({start_out, trip_out}, 2'b00)
    repeat (16) @(negedge clk_sys);
    `CHK(trip_level_ratio, 14'h0067)
    heal();
  endtask
  task automatic t_block();
    blk_in = 1'b1;
    pf_val = 8'sh32;
    step(1);
    `CHK({blocked_out, start_out}, 2'b10)
    blk_in = 1'b0;
    step(1);
    `CHK(start_out, 1'b1)
    blk_in = 1'b1;
    step(1);
    `CHK(start_out, 1'b0)
    blk_in = 1'b0;
    step(4);
    `CHK(trip_out, 1'b0)
    step(1);
    `CHK(trip_out, 1'b1)
    heal();
  endtask
  task automatic t_alarm();
    ld(pf_pkg::MODE_ON, 1'b1, 7'h32, 7'h5A);
    pf_val = 8'sh55;
    step(1);
    `CHK({alarm_start_out, start_out}, 2'b10)
    `CHK(alarm_expected, 19'h00003)
    repeat (16) @(negedge clk_sys);
    `CHK(alarm_level_ratio, 14'h005E)
    step(4);
    `CHK(alarm_out, 1'b1)
    ld(pf_pkg::MODE_ON, 1'b0, 7'h32, 7'h5A);
    step(1);
    `CHK({alarm_start_out, alarm_out}, 2'b00)
    repeat (16) @(negedge clk_sys);
    `CHK(alarm_level_ratio, 14'h0000)
    heal();
  endtask
  task automatic t_modes();
    ld(pf_pkg::MODE_OFF, 1'b1, 7'h50, 7'h32);
    pf_val = 8'sh32;
    step(1);
    `CHK({mode_now, start_out}, {pf_pkg::MODE_OFF, 1'b0})
    ld(pf_pkg::MODE_TEST, 1'b1, 7'h50, 7'h32);
    step(1);
    `CHK({condition, start_out}, {pf_pkg::COND_START, 1'b0})
    set_meas_sel = 1'b1;
    ld(pf_pkg::MODE_ON, 1'b1, 7'h50, 7'h32);
    step(2);
    `CHK(condition, pf_pkg::COND_NORMAL)
    cnt_clear = 1'b1;
    @(negedge clk_sys);
    cnt_clear = 1'b0;
    @(negedge clk_sys);
    `CHK(event_count[1], 16'h0000)
  endtask
  //------------------------------------------------------------
  // Verdict and main sequence
  //------------------------------------------------------------
  task automatic end_of_test();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    #1000000;
    failures++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK(mode_now, pf_pkg::MODE_ON)
    `CHK(condition, pf_pkg::COND_NORMAL)
    t_trip();
    t_block();
    t_alarm();
    t_modes();
    end_of_test();
  end
endmodule // power_factor_protection_stage_tb
